// file: hdl/apim_pin_drv.sv
// Registered polarity and enable stage for one alarm output pin.
`timescale 1ns/10ps
module apim_pin_drv (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic active_high,
  input wire logic enable,
  output logic pin_o,
  output logic pin_oe
);
  logic next_pin_o;
  logic next_pin_oe;

  // ==========================================================================
  // Active high passes the level; active low inverts it.
  always_comb begin
    next_pin_o = active_high ? active : ~active;
    next_pin_oe = enable;
  end

  // Reset drives the idle level of an active-high pin, released.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o <= next_pin_o;
      pin_oe <= next_pin_oe;
    end
  end
endmodule

// file: hdl/apim_top.sv
// Alarm interrupt combining, masking and output pin polarity control.
`timescale 1ns/10ps
module apim_top
  import apim_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic in1_signal_loss_flag,
  input wire logic in2_signal_loss_flag,
  input wire logic xtal_signal_loss_flag,
  input wire logic in1_freq_offset_flag,
  input wire logic in2_freq_offset_flag,
  input wire logic lock_loss_flag,
  input wire logic in1_bad_status,
  input wire logic in2_bad_status,
  input wire logic lock_loss_status,
  input wire logic clock_active_status,
  input wire logic irq_pin_enable,
  input wire logic in1_bad_pin_enable,
  input wire logic in2_bad_pin_enable,
  input wire logic lock_loss_pin_enable,
  input wire logic clock_active_pin_enable,
  output logic irq_status,
  output logic irq_or_in1_bad_pin_o,
  output logic irq_or_in1_bad_pin_oe,
  output logic in2_bad_pin_o,
  output logic in2_bad_pin_oe,
  output logic lock_loss_output_o,
  output logic lock_loss_output_oe,
  output logic clock_select_active_pin_o,
  output logic clock_select_active_pin_oe
);
  // ==========================================================================
  // Reset release: asserts at once, releases through two flops.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================================
  // Register file. Only the low polarity nibble and the low three mask bits
  // are writable; the rest reads its reset pattern, which is fixed.
  logic [APIM_FIELD_WIDTH-1:0] polarity;
  logic [APIM_MASK_WIDTH-1:0] sigloss_mask;
  logic [APIM_MASK_WIDTH-1:0] freqlock_mask;
  logic [APIM_FIELD_WIDTH-1:0] next_polarity;
  logic [APIM_MASK_WIDTH-1:0] next_sigloss_mask;
  logic [APIM_MASK_WIDTH-1:0] next_freqlock_mask;
  logic [7:0] next_reg_rdata;

  // Writes touch only the mask and polarity storage, never the flags.
  always_comb begin
    next_polarity = polarity;
    next_sigloss_mask = sigloss_mask;
    next_freqlock_mask = freqlock_mask;
    if (reg_wr) begin
      case (reg_addr)
        APIM_POLARITY_ADDR: next_polarity = reg_wdata[APIM_FIELD_WIDTH-1:0];
        APIM_SIGLOSS_MASK_ADDR: next_sigloss_mask = reg_wdata[APIM_MASK_WIDTH-1:0];
        APIM_FREQLOCK_MASK_ADDR: next_freqlock_mask = reg_wdata[APIM_MASK_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered; it holds its value between reads.
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        APIM_POLARITY_ADDR:
          next_reg_rdata = {APIM_POLARITY_RESET[7:APIM_FIELD_WIDTH], polarity};
        APIM_SIGLOSS_MASK_ADDR:
          next_reg_rdata = {APIM_SIGLOSS_MASK_RESET[7:APIM_MASK_WIDTH], sigloss_mask};
        APIM_FREQLOCK_MASK_ADDR:
          next_reg_rdata = {APIM_FREQLOCK_MASK_RESET[7:APIM_MASK_WIDTH], freqlock_mask};
        default: next_reg_rdata = APIM_UNMAPPED_READ;
      endcase
    end
  end

  // Reset leaves every alarm masked and every pin active high.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      polarity <= APIM_POLARITY_RESET[APIM_FIELD_WIDTH-1:0];
      sigloss_mask <= APIM_SIGLOSS_MASK_RESET[APIM_MASK_WIDTH-1:0];
      freqlock_mask <= APIM_FREQLOCK_MASK_RESET[APIM_MASK_WIDTH-1:0];
      reg_rdata <= 8'h00;
    end else begin
      polarity <= next_polarity;
      sigloss_mask <= next_sigloss_mask;
      freqlock_mask <= next_freqlock_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // Interrupt combining: a set mask bit removes that flag from the OR.
  logic next_irq_status;

  always_comb begin
    next_irq_status =
      (in2_signal_loss_flag & ~sigloss_mask[APIM_IN2_LOS_MASK_BIT]) |
      (in1_signal_loss_flag & ~sigloss_mask[APIM_IN1_LOS_MASK_BIT]) |
      (xtal_signal_loss_flag & ~sigloss_mask[APIM_XTAL_LOS_MASK_BIT]) |
      (in2_freq_offset_flag & ~freqlock_mask[APIM_IN2_FOS_MASK_BIT]) |
      (in1_freq_offset_flag & ~freqlock_mask[APIM_IN1_FOS_MASK_BIT]) |
      (lock_loss_flag & ~freqlock_mask[APIM_LOCK_LOSS_MASK_BIT]);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // ==========================================================================
  // Shared pin source selection. The interrupt and the input-1 bad status
  // share one pin, so the polarity follows whichever one is shown.
  logic shared_active;
  logic shared_high;
  logic shared_enable;

  always_comb begin
    shared_active = irq_pin_enable ? next_irq_status : in1_bad_status;
    shared_high = irq_pin_enable ? polarity[APIM_IRQ_POL_BIT]
                                 : polarity[APIM_CLOCK_BAD_POL_BIT];
    shared_enable = irq_pin_enable | in1_bad_pin_enable;
  end

  // ==========================================================================
  // Output pin stages, one cycle from cause to pin.
  apim_pin_drv u_shared_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(shared_active),
    .active_high(shared_high),
    .enable(shared_enable),
    .pin_o(irq_or_in1_bad_pin_o),
    .pin_oe(irq_or_in1_bad_pin_oe)
  );

  apim_pin_drv u_in2_bad_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(in2_bad_status),
    .active_high(polarity[APIM_CLOCK_BAD_POL_BIT]),
    .enable(in2_bad_pin_enable),
    .pin_o(in2_bad_pin_o),
    .pin_oe(in2_bad_pin_oe)
  );

  apim_pin_drv u_lock_loss_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(lock_loss_status),
    .active_high(polarity[APIM_LOCK_LOSS_POL_BIT]),
    .enable(lock_loss_pin_enable),
    .pin_o(lock_loss_output_o),
    .pin_oe(lock_loss_output_oe)
  );

  apim_pin_drv u_clock_active_pin (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(clock_active_status),
    .active_high(polarity[APIM_CLOCK_ACTIVE_POL_BIT]),
    .enable(clock_active_pin_enable),
    .pin_o(clock_select_active_pin_o),
    .pin_oe(clock_select_active_pin_oe)
  );

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_mask_write;
    reg_wr && (reg_addr == APIM_SIGLOSS_MASK_ADDR);
  endsequence

  // A read of the same mask two cycles on, with no write in between.
  sequence s_mask_read;
    !reg_wr ##1 (reg_rd && !reg_wr && (reg_addr == APIM_SIGLOSS_MASK_ADDR));
  endsequence

  a_clock_active_level: assert property (
    clock_select_active_pin_oe |->
      clock_select_active_pin_o == ($past(clock_active_status) ~^
                                    $past(polarity[APIM_CLOCK_ACTIVE_POL_BIT])))
    else $error("clock active pin level wrong");

  // The pin stages sit in reset one edge longer than the checks are disabled.
  a_in2_bad_level: assert property (
    $past(rst_n) |->
      in2_bad_pin_o == ($past(in2_bad_status) ~^ $past(polarity[APIM_CLOCK_BAD_POL_BIT])))
    else $error("input 2 bad pin level wrong");

  a_lock_loss_level: assert property (
    $past(rst_n) |->
      lock_loss_output_o == ($past(lock_loss_status) ~^
                             $past(polarity[APIM_LOCK_LOSS_POL_BIT])))
    else $error("lock loss pin level wrong");

  a_irq_pin_level: assert property (
    $past(irq_pin_enable) |->
      irq_or_in1_bad_pin_o == (irq_status ~^ $past(polarity[APIM_IRQ_POL_BIT])))
    else $error("interrupt pin level wrong");

  a_in2_los_unmasked: assert property (
    (in2_signal_loss_flag && !sigloss_mask[APIM_IN2_LOS_MASK_BIT]) |=> irq_status)
    else $error("input 2 signal loss did not raise interrupt");

  a_in1_los_unmasked: assert property (
    (in1_signal_loss_flag && !sigloss_mask[APIM_IN1_LOS_MASK_BIT]) |=> irq_status)
    else $error("input 1 signal loss did not raise interrupt");

  a_xtal_los_unmasked: assert property (
    (xtal_signal_loss_flag && !sigloss_mask[APIM_XTAL_LOS_MASK_BIT]) |=> irq_status)
    else $error("crystal signal loss did not raise interrupt");

  a_mask_write_store: assert property (
    s_mask_write ##1 s_mask_read |=>
      (reg_rdata[APIM_MASK_WIDTH-1:0] == $past(reg_wdata[APIM_MASK_WIDTH-1:0], 3)) &&
      (reg_rdata[7:APIM_MASK_WIDTH] == APIM_SIGLOSS_MASK_RESET[7:APIM_MASK_WIDTH]))
    else $error("mask write not stored");

  a_fos_lock_unmasked: assert property (
    ((in2_freq_offset_flag && !freqlock_mask[APIM_IN2_FOS_MASK_BIT]) ||
     (in1_freq_offset_flag && !freqlock_mask[APIM_IN1_FOS_MASK_BIT]) ||
     (lock_loss_flag && !freqlock_mask[APIM_LOCK_LOSS_MASK_BIT])) |=> irq_status)
    else $error("unmasked offset or lock alarm did not raise interrupt");

  a_all_masked_quiet: assert property (
    (&sigloss_mask[2:0] && &freqlock_mask[2:0]) |=> !irq_status)
    else $error("interrupt raised while all alarms masked");

  a_shared_tristate: assert property (
    (!irq_pin_enable && !in1_bad_pin_enable) |=> !irq_or_in1_bad_pin_oe)
    else $error("shared pin driven while both enables low");

  a_lock_loss_enable: assert property (
    lock_loss_pin_enable |=> lock_loss_output_oe ##0 $past(lock_loss_pin_enable))
    else $error("lock loss pin enable not followed");

  a_in2_enable: assert property (
    !in2_bad_pin_enable |=> !in2_bad_pin_oe)
    else $error("input 2 bad pin driven while disabled");
endmodule

// file: include/apim_pkg.sv
// Constants for the alarm pin polarity and interrupt mask block.
package apim_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] APIM_POLARITY_ADDR = 8'h16;
  localparam logic [7:0] APIM_SIGLOSS_MASK_ADDR = 8'h17;
  localparam logic [7:0] APIM_FREQLOCK_MASK_ADDR = 8'h18;
  // ==========================================================================
  // Values after reset
  localparam logic [7:0] APIM_POLARITY_RESET = 8'hdf;
  localparam logic [7:0] APIM_SIGLOSS_MASK_RESET = 8'h1f;
  localparam logic [7:0] APIM_FREQLOCK_MASK_RESET = 8'h3f;
  // ==========================================================================
  // Field positions
  localparam int APIM_CLOCK_ACTIVE_POL_BIT = 3;
  localparam int APIM_CLOCK_BAD_POL_BIT = 2;
  localparam int APIM_LOCK_LOSS_POL_BIT = 1;
  localparam int APIM_IRQ_POL_BIT = 0;
  localparam int APIM_IN2_LOS_MASK_BIT = 2;
  localparam int APIM_IN1_LOS_MASK_BIT = 1;
  localparam int APIM_XTAL_LOS_MASK_BIT = 0;
  localparam int APIM_IN2_FOS_MASK_BIT = 2;
  localparam int APIM_IN1_FOS_MASK_BIT = 1;
  localparam int APIM_LOCK_LOSS_MASK_BIT = 0;
  // Writable width of the polarity register; bits above are read-only.
  localparam int APIM_FIELD_WIDTH = 4;
  // Writable width of both mask registers; bit 3 and up are read-only.
  localparam int APIM_MASK_WIDTH = 3;
  localparam logic [7:0] APIM_UNMAPPED_READ = 8'h00;
endpackage

// file: verification/apim_pin_watch.sv
// Board-side model of the logic that watches the four alarm output pins.
`timescale 1ns/10ps
module apim_pin_watch (
  input wire logic mclk,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  output logic [3:0] level
);
  logic [3:0] last;

  // Remember the last level that each pin was actually driven to.
  always_ff @(posedge mclk) begin
    last <= (pin_oe & pin_o) | (~pin_oe & last);
  end

  // A released pin floats, so show the inverse of its last level to keep a stale value from passing.
  assign level = (pin_oe & pin_o) | (~pin_oe & ~last);
endmodule

// file: verification/tb.sv
// Self-checking bench for the alarm pin polarity and interrupt mask block.
`timescale 1ns/10ps
module tb;
  import apim_pkg::*;
  logic mclk, resetn, reg_wr, reg_rd, irq_status;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pol, msl, mfl;
  logic [5:0] fl;
  logic [3:0] st, po, oe, lvl;
  logic [4:0] en;
  logic [31:0] r;
  int n_fail, n_checks, seed, i;

  // ==========================================================================
  // Design and board model
  apim_top u_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in2_signal_loss_flag(fl[5]), .in1_signal_loss_flag(fl[4]), .xtal_signal_loss_flag(fl[3]),
    .in2_freq_offset_flag(fl[2]), .in1_freq_offset_flag(fl[1]), .lock_loss_flag(fl[0]),
    .in1_bad_status(st[0]), .in2_bad_status(st[1]), .lock_loss_status(st[2]),
    .clock_active_status(st[3]), .irq_pin_enable(en[0]), .in1_bad_pin_enable(en[1]),
    .in2_bad_pin_enable(en[2]), .lock_loss_pin_enable(en[3]), .clock_active_pin_enable(en[4]),
    .irq_status(irq_status), .irq_or_in1_bad_pin_o(po[0]), .irq_or_in1_bad_pin_oe(oe[0]),
    .in2_bad_pin_o(po[1]), .in2_bad_pin_oe(oe[1]), .lock_loss_output_o(po[2]),
    .lock_loss_output_oe(oe[2]), .clock_select_active_pin_o(po[3]),
    .clock_select_active_pin_oe(oe[3]));
  apim_pin_watch u_watch (.mclk(mclk), .pin_o(po), .pin_oe(oe), .level(lvl));

  // ==========================================================================
  // Checking helpers
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic lv(input logic p, input logic s);
    return p ? s : !s;
  endfunction

  // Work out the interrupt and every pin from the model registers and inputs.
  task check_pins();
    logic irq;
    irq = |(fl & ~{msl[2:0], mfl[2:0]});
    chk(irq_status, irq);
    chk(oe, {en[4], en[3], en[2], en[0] | en[1]});
    if (oe[0]) chk(lvl[0], en[0] ? lv(pol[0], irq) : lv(pol[2], st[0]));
    if (oe[1]) chk(lvl[1], lv(pol[2], st[1]));
    if (oe[2]) chk(lvl[2], lv(pol[1], st[2]));
    if (oe[3]) chk(lvl[3], lv(pol[3], st[3]));
  endtask

  // ==========================================================================
  // Register port and input drivers
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Polarity keeps its low nibble, each mask its low three bits; the rest
  // keeps the reset pattern.
  task wreg(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    if (a == APIM_POLARITY_ADDR) pol = {APIM_POLARITY_RESET[7:4], d[3:0]};
    if (a == APIM_SIGLOSS_MASK_ADDR) msl = {APIM_SIGLOSS_MASK_RESET[7:3], d[2:0]};
    if (a == APIM_FREQLOCK_MASK_ADDR) mfl = {APIM_FREQLOCK_MASK_RESET[7:3], d[2:0]};
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk(reg_rdata, exp);
  endtask

  task drive(input logic [5:0] f, input logic [3:0] s, input logic [4:0] e);
    @(posedge mclk);
    fl <= f;
    st <= s;
    en <= e;
  endtask

  // Pins answer one cycle after their inputs; three edges cover a mask write too.
  task settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task stop_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // The run needs about thirteen hundred cycles; this limit of 8000 cycles leaves ample slack.
  initial begin
    #(25 * 8000);
    n_fail++;
    stop_test();
  end

  initial begin
    seed = 32'hcf38;
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fl = 6'h3f;
    st = 4'hf;
    en = 5'h1f;
    pol = APIM_POLARITY_RESET;
    msl = APIM_SIGLOSS_MASK_RESET;
    mfl = APIM_FREQLOCK_MASK_RESET;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(APIM_POLARITY_ADDR, 8'hdf);
    rd(APIM_SIGLOSS_MASK_ADDR, 8'h1f);
    rd(APIM_FREQLOCK_MASK_ADDR, 8'h3f);
    rd(8'h19, 8'h00);
    settle();
    check_pins();
    // Walk each flag alone with nothing masked, then mask just that flag.
    wreg(APIM_POLARITY_ADDR, 8'h00);
    wreg(APIM_SIGLOSS_MASK_ADDR, 8'h00);
    wreg(APIM_FREQLOCK_MASK_ADDR, 8'h00);
    for (i = 0; i < 6; i++) begin
      drive(6'h01 << i, 4'h5, 5'h1d);
      settle();
      check_pins();
      if (i < 3) wreg(APIM_FREQLOCK_MASK_ADDR, 8'h01 << i);
      else wreg(APIM_SIGLOSS_MASK_ADDR, 8'h01 << (i - 3));
      settle();
      check_pins();
      wreg(APIM_SIGLOSS_MASK_ADDR, 8'h00);
      wreg(APIM_FREQLOCK_MASK_ADDR, 8'h00);
    end
    // A write to an unmapped address must leave the polarity register alone.
    wr(8'h20, 8'hff);
    rd(APIM_POLARITY_ADDR, 8'hd0);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      wreg(APIM_POLARITY_ADDR, r[7:0]);
      wreg(APIM_SIGLOSS_MASK_ADDR, r[15:8]);
      // Reading straight after the write exercises the write-then-read check.
      rd(APIM_SIGLOSS_MASK_ADDR, msl);
      wreg(APIM_FREQLOCK_MASK_ADDR, r[23:16]);
      r = $random(seed);
      drive(r[5:0], r[9:6], r[14:10]);
      settle();
      check_pins();
      rd(APIM_SIGLOSS_MASK_ADDR, msl);
      rd(APIM_FREQLOCK_MASK_ADDR, mfl);
    end
    stop_test();
  end
endmodule
